// [dv/testbench.sv]
// Self-checking bench for the two-channel PWM block
`timescale 1ns/1ps
module testbench
	import tpw_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic pulse_out_first;
	logic pulse_out_second;
	int fail_count = 0;
	int total_checks = 0;
	always #50 ref_clk = ~ref_clk;
	tpw_pwm u_tpw_pwm (.ref_clk(ref_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pulse_out_first(pulse_out_first),
		.pulse_out_second(pulse_out_second));
	tpw_host u_tpw_host (.ref_clk(ref_clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		u_tpw_host.xfer(1'b0, a, 32'h0, q);
	endtask : rd
	// Send a command, then check reply and status
	task automatic cmd(input string s, input logic [31:0] rep,
		input logic [31:0] st);
		logic [31:0] q;
		u_tpw_host.send(s);
		rd(ADDR_REPLY, q);
		chk(q, rep);
		rd(ADDR_STATUS, q);
		chk(q, st);
	endtask : cmd
	// High cycles of each output over n cycles
	task automatic highs(input int n, input int e1, input int e2);
		int h1;
		int h2;
		h1 = 0;
		h2 = 0;
		repeat (n)
		begin
			@(negedge ref_clk);
			h1 += (pulse_out_first === 1'b1);
			h2 += (pulse_out_second === 1'b1);
		end
		chk(32'(h1), 32'(e1));
		chk(32'(h2), 32'(e2));
	endtask : highs
	task automatic t_fast;
		cmd("[,1,3,000A,0005", 32'h3, 32'h107);
		highs(20, 10, 0);
		$display("test fast done");
	endtask : t_fast
	task automatic t_mid;
		cmd("[,2,2,4,1", 32'h3, 32'h157);
		highs(180, 90, 45);
		$display("test mid done");
	endtask : t_mid
	task automatic t_slow;
		cmd("[,1,1,2,1", 32'h3, 32'h153);
		highs(1872, 936, 468);
		$display("test slow done");
	endtask : t_slow
	task automatic t_off;
		cmd("[,1,0,FFFF,FFFF", 32'h3, 32'h150);
		highs(36, 0, 9);
		$display("test off done");
	endtask : t_off
	task automatic t_res;
		logic [31:0] q;
		u_tpw_host.xfer(1'b1, ADDR_PINRES, 32'h2, q);
		rd(ADDR_PINRES, q);
		chk(q, 32'h2);
		cmd("[,2,0", 32'h1, 32'h150);
		highs(36, 0, 9);
		u_tpw_host.xfer(1'b1, ADDR_PINRES, 32'h0, q);
		$display("test reserve done");
	endtask : t_res
	task automatic t_err;
		logic [31:0] q;
		cmd("[,3,1,4,1", 32'h1, 32'h150);
		cmd("[,1,2", 32'h1, 32'h150);
		cmd("[,1,2,12345,1", 32'h1, 32'h150);
		cmd("[,1,4,4,1", 32'h1, 32'h150);
		rd(4'h1, q);
		chk(q, 32'h0);
		$display("test error done");
	endtask : t_err
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	initial
	begin
		#2_000_000;
		fail_count++;
		close_out();
	end
	initial
	begin
		logic [31:0] q;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(ADDR_STATUS, q);
		chk(q, 32'h100);
		t_fast();
		t_mid();
		t_slow();
		t_off();
		t_res();
		t_err();
		close_out();
	end
endmodule : testbench

// [dv/tpw_host.sv]
// Host model that issues Avalon-MM transfers to the PWM block
`timescale 1ns/1ps
module tpw_host
	import tpw_pkg::*;
(
	// Clock
	input wire logic ref_clk,
	// Avalon-MM master side
	output logic [3:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial
	begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
	end
	// One transfer, held until waitrequest is seen low at a rising edge
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer
	// One command string, ended by carriage return
	task automatic send(input string s);
		logic [31:0] q;
		for (int i = 0; i < s.len(); i++)
			xfer(1'b1, ADDR_CMD, {24'h0, s[i]}, q);
		xfer(1'b1, ADDR_CMD, {24'h0, CH_CR}, q);
	endtask : send
endmodule : tpw_host

// [src/tpw_pkg.sv]
// Constants, types and encodings for the two-channel text-configured PWM
package tpw_pkg;
	// Clock and count units, times in picoseconds
	localparam int CLK_PS = 100_000;
	localparam int UNIT_32K_PS = 31_250_000;
	localparam int UNIT_1M_PS = 977_000;
	localparam int UNIT_16M_PS = 62_500;
	localparam int DIV_32K = (UNIT_32K_PS / CLK_PS < 1) ? 1 :
		UNIT_32K_PS / CLK_PS;
	localparam int DIV_1M = (UNIT_1M_PS / CLK_PS < 1) ? 1 :
		UNIT_1M_PS / CLK_PS;
	localparam int DIV_16M = (UNIT_16M_PS / CLK_PS < 1) ? 1 :
		UNIT_16M_PS / CLK_PS;
	localparam logic [9:0] DIV_LAST [1:3] = '{10'(DIV_32K - 1),
		10'(DIV_1M - 1), 10'(DIV_16M - 1)};
	// Register byte offsets
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_REPLY = 4'h4;
	localparam logic [3:0] ADDR_PINRES = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hC;
	// Field positions
	localparam int REPLY_VALID_BIT = 0;
	localparam int REPLY_OK_BIT = 1;
	localparam int STAT_CH2_LSB = 4;
	localparam int STAT_IDLE_BIT = 8;
	localparam logic [1:0] PINRES_RESET = 2'h0;
	// Command characters
	localparam logic [7:0] CH_OPEN = 8'h5B;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_TWO = 8'h32;
	localparam logic [7:0] CH_THREE = 8'h33;
	localparam logic [2:0] HEX_DIGITS = 3'h4;
	localparam logic [1:0] OP_OFF = 2'h0;
	// Channel setting
	typedef struct packed {
		logic en;
		logic [1:0] clk;
		logic [15:0] max;
		logic [15:0] cmp;
	} tpw_chan_t;
	// Parser states, Gray along the usual path
	typedef enum logic [3:0] {
		P_IDLE = 4'h0,
		P_C1 = 4'h1,
		P_CH = 4'h3,
		P_C2 = 4'h2,
		P_OP = 4'h6,
		P_SEP = 4'h7,
		P_MAX = 4'h5,
		P_CMP = 4'h4,
		P_ERR = 4'hC
	} tpw_state_t;
endpackage : tpw_pkg

// [src/tpw_pwm.sv]
// Two-channel PWM with text command parser behind an Avalon-MM slave
`timescale 1ns/1ps
module tpw_pwm
	import tpw_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Modulated outputs
	output logic pulse_out_first,
	output logic pulse_out_second
);

	function automatic logic [4:0] hex_val(input logic [7:0] c);
		logic [4:0] v;
		v = 5'h00;
		if (c >= 8'h30 && c <= 8'h39)
			v = {1'b1, c[3:0]};
		else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
			v = {1'b1, 4'(c[3:0] + 4'h9)};
		return v;
	endfunction : hex_val

	// Bus slave: one wait cycle, answer on the second edge
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic req, acc;
	logic [1:0] pinres_r, pinres_nxt;
	logic rep_vld_r, rep_vld_nxt, rep_ok_r, rep_ok_nxt;
	tpw_state_t st_r, st_nxt;
	tpw_chan_t chan_r [2];
	tpw_chan_t chan_nxt [2];
	logic ch_r, ch_nxt;
	logic [1:0] op_r, op_nxt;
	logic [15:0] max_r, max_nxt, cmp_r, cmp_nxt;
	logic [2:0] nd_r, nd_nxt;
	logic [7:0] chr;
	logic chr_vld, done, ok;
	logic [4:0] hx;

	assign req = avs_read | avs_write;
	assign acc = req & ack_r;
	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata = rdata_r;
	assign chr = avs_writedata[7:0];
	assign chr_vld = acc & avs_write & (avs_address == ADDR_CMD);
	assign hx = hex_val(chr);

	always_comb
	begin
		ack_nxt = req & ~ack_r;
		rdata_nxt = rdata_r;
		pinres_nxt = pinres_r;
		if (req & ~ack_r)
		begin
			rdata_nxt = 32'h0;
			unique case (avs_address)
				ADDR_REPLY: rdata_nxt = 32'({rep_ok_r, rep_vld_r});
				ADDR_PINRES: rdata_nxt = 32'(pinres_r);
				ADDR_STATUS:
				begin
					rdata_nxt[STAT_IDLE_BIT] = (st_r == P_IDLE);
					rdata_nxt[2:0] = {chan_r[0].clk, chan_r[0].en};
					rdata_nxt[STAT_CH2_LSB +: 3] = {chan_r[1].clk, chan_r[1].en};
				end
				default: rdata_nxt = 32'h0;
			endcase
		end
		if (acc & avs_write & (avs_address == ADDR_PINRES))
			pinres_nxt = avs_writedata[1:0];
	end

	// Command parser
	always_comb
	begin
		st_nxt = st_r;
		ch_nxt = ch_r;
		op_nxt = op_r;
		max_nxt = max_r;
		cmp_nxt = cmp_r;
		nd_nxt = nd_r;
		done = 1'b0;
		ok = 1'b0;
		if (chr_vld && chr == CH_CR && st_r != P_IDLE)
		begin
			done = 1'b1;
			st_nxt = P_IDLE;
			ok = (st_r == P_SEP && op_r == OP_OFF) ||
				(st_r == P_CMP && nd_r != 3'h0);
		end
		else if (chr_vld)
		begin
			st_nxt = P_ERR;
			unique case (st_r)
				P_IDLE:
					if (chr == CH_OPEN)
						st_nxt = P_C1;
					else if (chr == CH_CR)
						st_nxt = P_IDLE;
				P_C1:
					if (chr == CH_COMMA)
						st_nxt = P_CH;
				P_CH:
					if (chr == CH_ONE || chr == CH_TWO)
					begin
						ch_nxt = (chr == CH_TWO);
						st_nxt = P_C2;
					end
				P_C2:
					if (chr == CH_COMMA)
						st_nxt = P_OP;
				P_OP:
					if (chr >= CH_ZERO && chr <= CH_THREE)
					begin
						op_nxt = chr[1:0];
						st_nxt = P_SEP;
					end
				P_SEP:
					if (chr == CH_COMMA)
					begin
						max_nxt = 16'h0;
						nd_nxt = 3'h0;
						st_nxt = P_MAX;
					end
				P_MAX:
					if (hx[4] && nd_r < HEX_DIGITS)
					begin
						max_nxt = {max_r[11:0], hx[3:0]};
						nd_nxt = nd_r + 3'h1;
						st_nxt = P_MAX;
					end
					else if (chr == CH_COMMA && nd_r != 3'h0)
					begin
						cmp_nxt = 16'h0;
						nd_nxt = 3'h0;
						st_nxt = P_CMP;
					end
				P_CMP:
					if (hx[4] && nd_r < HEX_DIGITS)
					begin
						cmp_nxt = {cmp_r[11:0], hx[3:0]};
						nd_nxt = nd_r + 3'h1;
						st_nxt = P_CMP;
					end
				P_ERR: st_nxt = P_ERR;
				default: st_nxt = P_ERR;
			endcase
		end
	end

	// Apply and reply
	always_comb
	begin
		chan_nxt = chan_r;
		rep_vld_nxt = rep_vld_r;
		rep_ok_nxt = rep_ok_r;
		if (acc & avs_read & (avs_address == ADDR_REPLY))
			rep_vld_nxt = 1'b0;
		if (done)
		begin
			rep_vld_nxt = 1'b1;
			rep_ok_nxt = ok & ~pinres_r[ch_r];
			if (ok && !pinres_r[ch_r])
			begin
				chan_nxt[ch_r].en = (op_r != OP_OFF);
				chan_nxt[ch_r].clk = op_r;
				if (op_r != OP_OFF)
				begin
					chan_nxt[ch_r].max = max_r;
					chan_nxt[ch_r].cmp = cmp_r;
				end
			end
		end
	end

	// Unit dividers and channel counters
	logic [9:0] div_r [1:3];
	logic [9:0] div_nxt [1:3];
	logic [3:0] tick;
	logic [15:0] cnt_r [2];
	logic [15:0] cnt_nxt [2];
	logic [1:0] pulse_r, pulse_nxt;
	logic [1:0] ctick;

	always_comb
	begin
		tick = 4'h0;
		for (int i = 1; i <= 3; i++)
		begin
			tick[i] = (div_r[i] == DIV_LAST[i]);
			div_nxt[i] = tick[i] ? 10'h0 : div_r[i] + 10'h1;
		end
		for (int c = 0; c < 2; c++)
		begin
			ctick[c] = tick[chan_r[c].clk];
			cnt_nxt[c] = cnt_r[c];
			if (done && ok && ch_r == c[0])
				cnt_nxt[c] = 16'h0;
			else if (!chan_r[c].en || chan_r[c].max == 16'h0)
				cnt_nxt[c] = 16'h0;
			else if (ctick[c])
				cnt_nxt[c] = (cnt_r[c] >= chan_r[c].max - 16'h1) ?
					16'h0 : cnt_r[c] + 16'h1;
			pulse_nxt[c] = chan_nxt[c].en && chan_nxt[c].max != 16'h0 &&
				cnt_nxt[c] < chan_nxt[c].cmp;
		end
	end

	assign pulse_out_first = pulse_r[0];
	assign pulse_out_second = pulse_r[1];

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0;
			pinres_r <= PINRES_RESET;
			rep_vld_r <= 1'b0;
			rep_ok_r <= 1'b0;
			st_r <= P_IDLE;
			ch_r <= 1'b0;
			op_r <= 2'h0;
			max_r <= 16'h0;
			cmp_r <= 16'h0;
			nd_r <= 3'h0;
			chan_r <= '{default: '0};
			div_r <= '{default: '0};
			cnt_r <= '{default: '0};
			pulse_r <= 2'h0;
		end
		else
		begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			pinres_r <= pinres_nxt;
			rep_vld_r <= rep_vld_nxt;
			rep_ok_r <= rep_ok_nxt;
			st_r <= st_nxt;
			ch_r <= ch_nxt;
			op_r <= op_nxt;
			max_r <= max_nxt;
			cmp_r <= cmp_nxt;
			nd_r <= nd_nxt;
			chan_r <= chan_nxt;
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	// Checks
	localparam int D1M = DIV_1M;
	localparam int D32K = DIV_32K;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	reply_on_cr_a: assert property (done |=> rep_vld_r)
		else $error("no reply after command end");
	bad_syntax_a: assert property (done && !ok |=> !rep_ok_r)
		else $error("bad command answered as accepted");
	pin_block_a: assert property (done && pinres_r[ch_r]
		|=> !rep_ok_r && $stable(chan_r[0]) && $stable(chan_r[1]))
		else $error("reserved pin changed or accepted");
	off_op_a: assert property (done && ok && op_r == OP_OFF &&
		!pinres_r[ch_r] |=> !chan_r[ch_r].en && $stable(chan_r[ch_r].max))
		else $error("disable did not act or changed values");
	clk_sel_a: assert property (done && ok && op_r != OP_OFF &&
		!pinres_r[ch_r] |=> chan_r[ch_r].en && chan_r[ch_r].clk == $past(op_r)
		&& chan_r[ch_r].max == $past(max_r))
		else $error("enable did not load clock or maximum");
	unit_1m_a: assert property (tick[2] |-> ##[D1M:D1M] tick[2])
		else $error("1024 kHz unit spacing wrong");
	wrap_a: assert property (chan_r[0].en && ctick[0] &&
		chan_r[0].max != 16'h0 && cnt_r[0] == chan_r[0].max - 16'h1 &&
		!(done && ok) |=> cnt_r[0] == 16'h0)
		else $error("counter did not wrap at maximum");
	duty_a: assert property (pulse_out_second == (chan_r[1].en &&
		chan_r[1].max != 16'h0 && cnt_r[1] < chan_r[1].cmp))
		else $error("output level does not match count");
	wait_once_a: assert property (req && !ack_r |=> !avs_waitrequest)
		else $error("bus answer late");
	unit_32k_a: assert property (tick[1] |-> ##[D32K:D32K] tick[1])
		else $error("32 kHz unit spacing wrong");
	duty_first_a: assert property (pulse_out_first == (chan_r[0].en &&
		chan_r[0].max != 16'h0 && cnt_r[0] < chan_r[0].cmp))
		else $error("first output level does not match count");
	off_low_a: assert property (!chan_r[0].en |-> !pulse_out_first)
		else $error("disabled channel output not low");
	reply_clear_a: assert property (acc && avs_read &&
		avs_address == ADDR_REPLY && !done |=> !rep_vld_r)
		else $error("reply flag not cleared by read");
	apply_cv: cover property (done && ok && !pinres_r[ch_r]);
	off_cv: cover property (done && ok && op_r == OP_OFF);
	refuse_cv: cover property (done && ok && pinres_r[ch_r]);
	error_cv: cover property (done && !ok);
	pulse_cv: cover property ($rose(pulse_out_first));
endmodule : tpw_pwm
